// ==== include/asr_pkg.sv ====
// Package for the axis signal router: register map, field layout, types.
package asr_pkg;
  localparam int ASR_AW = 5;
  localparam logic [4:0] ASR_OFF_INTERRUPT_STATUS = 5'h10;
  localparam logic [4:0] ASR_OFF_PGM = 5'h14;
  localparam logic [4:0] ASR_OFF_IRQSEL = 5'h16;
  localparam logic [4:0] ASR_OFF_OUTSEL = 5'h18;
  localparam logic [15:0] ASR_RST_PGM = 16'h0000;
  localparam logic [3:0] ASR_RST_IRQSEL = 4'h0;
  localparam logic [7:0] ASR_RST_OUTSEL = 8'h00;
  localparam logic [15:0] ASR_IRQ_OK_MASK = 16'h9CB0;
  localparam int ASR_FIELD_W = 4;
  localparam int ASR_TYPE_BIT = 3;
  localparam logic [2:0] ASR_CONN_OFF = 3'h0;
  localparam logic [2:0] ASR_CONN_OWN = 3'h1;
  localparam logic [2:0] ASR_CONN_SWX = 3'h2;
  localparam logic [2:0] ASR_CONN_SWY = 3'h3;
  localparam logic [2:0] ASR_CONN_FIX = 3'h4;
  typedef struct packed {
    logic plus;
    logic minus;
  } asr_pulse_t;
  typedef enum logic [1:0] {
    ASR_BUS_IDLE = 2'h1,
    ASR_BUS_ACK = 2'h2
  } asr_bus_st_t;
endpackage

// ==== verilog/asr_router.sv ====
// Axis pulse router, interrupt line select and shared output pin mux.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module asr_router
  import asr_pkg::*;
#(
  parameter int AXES = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ASR_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire asr_pulse_t [AXES-1:0] ext_pulse_pair,
  input wire logic axis_pick_hi,
  input wire logic axis_pick_lo,
  input wire logic irq_event,
  input wire logic [AXES-1:0] gen_output_six,
  input wire logic [AXES-1:0] gen_output_two,
  input wire logic [AXES-1:0] gen_output_seven,
  input wire logic [AXES-1:0] gen_output_three,
  output asr_pulse_t [AXES-1:0] axis_drive,
  output logic [AXES-1:0] axis_handwheel,
  output logic [AXES-1:0] shared_pin_a,
  output logic [AXES-1:0] shared_pin_b,
  output logic [15:0] host_irq
);
  if (AXES != 4) begin : g_chk
    $error("asr_router serves exactly four axes");
  end

  asr_bus_st_t bus_q, bus_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] pulse_gen_mode_word_q, pulse_gen_mode_word_d;
  logic [3:0] irq_line_select_q, irq_line_select_d;
  logic [7:0] output_pin_select_q, output_pin_select_d;
  logic irq_flag_q, irq_flag_d;
  logic wait_q, wait_d;
  logic wr_fire, rd_fire;

  // Each access is answered one cycle after it is first presented.
  assign wr_fire = (bus_q == ASR_BUS_ACK) && avs_write;
  assign rd_fire = (bus_q == ASR_BUS_ACK) && avs_read;

  always_comb begin
    bus_d = bus_q;
    rdata_d = rdata_q;
    pulse_gen_mode_word_d = pulse_gen_mode_word_q;
    irq_line_select_d = irq_line_select_q;
    output_pin_select_d = output_pin_select_q;
    irq_flag_d = irq_flag_q;
    case (bus_q)
      ASR_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_d = ASR_BUS_ACK;
        end
        rdata_d = '0;
        case (avs_address)
          ASR_OFF_INTERRUPT_STATUS: rdata_d[0] = irq_flag_q;
          ASR_OFF_PGM: rdata_d[15:0] = pulse_gen_mode_word_q;
          ASR_OFF_IRQSEL: rdata_d[3:0] = irq_line_select_q;
          ASR_OFF_OUTSEL: rdata_d[7:0] = output_pin_select_q;
          default: rdata_d = '0;
        endcase
      end
      ASR_BUS_ACK: begin
        bus_d = ASR_BUS_IDLE;
      end
      default: bus_d = ASR_BUS_IDLE;
    endcase
    if (wr_fire) begin
      case (avs_address)
        ASR_OFF_INTERRUPT_STATUS: irq_flag_d = 1'b0;
        ASR_OFF_PGM: pulse_gen_mode_word_d = avs_writedata[15:0];
        ASR_OFF_IRQSEL: irq_line_select_d = avs_writedata[3:0];
        ASR_OFF_OUTSEL: output_pin_select_d = avs_writedata[7:0];
        default: ;
      endcase
    end
    // A new event in the clearing cycle wins, so none is lost.
    if (irq_event) begin
      irq_flag_d = 1'b1;
    end
    // Waitrequest is a flop of its own so the pin never glitches.
    wait_d = (bus_d != ASR_BUS_ACK);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_q <= ASR_BUS_IDLE;
      rdata_q <= '0;
      pulse_gen_mode_word_q <= ASR_RST_PGM;
      irq_line_select_q <= ASR_RST_IRQSEL;
      output_pin_select_q <= ASR_RST_OUTSEL;
      irq_flag_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
      bus_q <= bus_d;
      rdata_q <= rdata_d;
      pulse_gen_mode_word_q <= pulse_gen_mode_word_d;
      irq_line_select_q <= irq_line_select_d;
      output_pin_select_q <= output_pin_select_d;
      irq_flag_q <= irq_flag_d;
    end
  end

  assign avs_readdata = rdata_q;
  // Waitrequest is high except in the answering cycle; idle high is legal.
  assign avs_waitrequest = wait_q;

  // Routing: per target axis, collect contributions from all fields.
  logic [1:0] pick;
  asr_pulse_t [AXES-1:0] drive_d, drive_q;
  logic [AXES-1:0] hw_d, hw_q, pin_a_d, pin_a_q, pin_b_d, pin_b_q;
  logic [15:0] irq_d, irq_q;

  assign pick = {axis_pick_hi, axis_pick_lo};

  always_comb begin
    logic [2:0] conn;
    drive_d = '0;
    hw_d = '0;
    conn = '0;
    for (int src = 0; src < AXES; src++) begin
      conn = pulse_gen_mode_word_q[src*ASR_FIELD_W +: 3];
      if (conn == ASR_CONN_OWN) begin
        drive_d[src] = drive_d[src] | ext_pulse_pair[src];
        hw_d[src] = pulse_gen_mode_word_q[src*ASR_FIELD_W+ASR_TYPE_BIT];
      end else if (conn == ASR_CONN_SWX) begin
        drive_d[pick] = drive_d[pick] | ext_pulse_pair[0];
        hw_d[pick] = pulse_gen_mode_word_q[src*ASR_FIELD_W+ASR_TYPE_BIT];
      end else if (conn == ASR_CONN_SWY) begin
        drive_d[pick] = drive_d[pick] | ext_pulse_pair[1];
        hw_d[pick] = pulse_gen_mode_word_q[src*ASR_FIELD_W+ASR_TYPE_BIT];
      end else if (conn[2]) begin
        drive_d[src] = drive_d[src] | ext_pulse_pair[conn[1:0]];
        hw_d[src] = pulse_gen_mode_word_q[src*ASR_FIELD_W+ASR_TYPE_BIT];
      end
    end
    for (int a = 0; a < AXES; a++) begin
      pin_a_d[a] = output_pin_select_q[2*a] ? gen_output_two[a]
                                            : gen_output_six[a];
      pin_b_d[a] = output_pin_select_q[2*a+1] ? gen_output_three[a]
                                              : gen_output_seven[a];
    end
    irq_d = '0;
    if (ASR_IRQ_OK_MASK[irq_line_select_q]) begin
      irq_d[irq_line_select_q] = irq_flag_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drive_q <= '0;
      hw_q <= '0;
      pin_a_q <= '0;
      pin_b_q <= '0;
      irq_q <= '0;
    end else begin
      drive_q <= drive_d;
      hw_q <= hw_d;
      pin_a_q <= pin_a_d;
      pin_b_q <= pin_b_d;
      irq_q <= irq_d;
    end
  end

  assign axis_drive = drive_q;
  assign axis_handwheel = hw_q;
  assign shared_pin_a = pin_a_q;
  assign shared_pin_b = pin_b_q;
  assign host_irq = irq_q;

  AST_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_fire && avs_address == ASR_OFF_INTERRUPT_STATUS && !irq_event |=> !irq_flag_q)
    else $error("flag not cleared by write");
  AST_SET: assert property (@(posedge mclk) disable iff (sys_rst)
    irq_event |=> irq_flag_q)
    else $error("event did not set flag");
  AST_IRQ_BAD: assert property (@(posedge mclk) disable iff (sys_rst)
    !ASR_IRQ_OK_MASK[$past(irq_line_select_q)] |-> host_irq == '0)
    else $error("irq driven on unsupported line");
  AST_IRQ_ONLY: assert property (@(posedge mclk) disable iff (sys_rst)
    (host_irq & ~ASR_IRQ_OK_MASK) == '0)
    else $error("irq on unsupported line");
  AST_SEL_RB: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_fire && avs_address == ASR_OFF_IRQSEL
    |=> irq_line_select_q == $past(avs_writedata[3:0]))
    else $error("line number not stored");
  AST_PIN_A: assert property (@(posedge mclk) disable iff (sys_rst)
    !output_pin_select_q[0] |=> shared_pin_a[0] == $past(gen_output_six[0]))
    else $error("pin a mux wrong");
  AST_OWN: assert property (@(posedge mclk) disable iff (sys_rst)
    pulse_gen_mode_word_q == 16'h1111 |=> axis_drive == $past(ext_pulse_pair))
    else $error("own routing wrong");
  AST_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
    pulse_gen_mode_word_q == '0 |=> axis_drive == '0)
    else $error("drive while disabled");
  AST_BUS: assert property (@(posedge mclk) disable iff (sys_rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer in one cycle");

  // Steps of the register bus and of the routing checks below.
  sequence s_clr_wr;
    wr_fire && avs_address == ASR_OFF_INTERRUPT_STATUS;
  endsequence

  sequence s_out_wr;
    wr_fire && avs_address == ASR_OFF_OUTSEL;
  endsequence

  sequence s_pgm_wr;
    wr_fire && avs_address == ASR_OFF_PGM;
  endsequence

  sequence s_swx_y;
    pulse_gen_mode_word_q == 16'h0002 && pick == 2'h1;
  endsequence

  sequence s_swy_u;
    pulse_gen_mode_word_q == 16'h0003 && pick == 2'h3;
  endsequence

  // A clear that meets a new event must not lose that event.
  AST_SET_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
    s_clr_wr ##0 irq_event |=> irq_flag_q)
    else $error("event lost in clearing cycle");
  AST_IRQ_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
    !irq_flag_q |=> host_irq == '0)
    else $error("irq driven without flag");
  AST_IRQ_ON: assert property (@(posedge mclk) disable iff (sys_rst)
    ASR_IRQ_OK_MASK[irq_line_select_q] && irq_flag_q
    |=> host_irq == (16'h0001 << $past(irq_line_select_q)))
    else $error("irq not on selected line");
  AST_RD_FLAG: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_fire && avs_address == ASR_OFF_INTERRUPT_STATUS
    |-> avs_readdata[0] == $past(irq_flag_q))
    else $error("flag read wrong");
  AST_RD_SEL: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_fire && avs_address == ASR_OFF_IRQSEL
    |-> avs_readdata[3:0] == irq_line_select_q)
    else $error("line number read wrong");
  AST_RD_OUT: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_fire && avs_address == ASR_OFF_OUTSEL
    |-> avs_readdata[7:0] == output_pin_select_q)
    else $error("select read wrong");
  AST_OUT_WR: assert property (@(posedge mclk) disable iff (sys_rst)
    s_out_wr |=> output_pin_select_q == $past(avs_writedata[7:0]))
    else $error("selects not stored");
  AST_PGM_WR: assert property (@(posedge mclk) disable iff (sys_rst)
    s_pgm_wr |=> pulse_gen_mode_word_q == $past(avs_writedata[15:0]))
    else $error("mode word not stored");
  AST_WAIT: assert property (@(posedge mclk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");

  // Reset checks run while reset is high, so they carry no disable.
  AST_RST_SEL: assert property (@(posedge mclk)
    sys_rst |=> irq_line_select_q == ASR_RST_IRQSEL)
    else $error("line number not reset");
  AST_RST_CFG: assert property (@(posedge mclk)
    sys_rst |=> output_pin_select_q == ASR_RST_OUTSEL
      && pulse_gen_mode_word_q == ASR_RST_PGM)
    else $error("routing not reset");

  AST_PIN_A1: assert property (@(posedge mclk) disable iff (sys_rst)
    output_pin_select_q[0] |=> shared_pin_a[0] == $past(gen_output_two[0]))
    else $error("pin a alternate wrong");
  AST_PIN_B0: assert property (@(posedge mclk) disable iff (sys_rst)
    !output_pin_select_q[1]
    |=> shared_pin_b[0] == $past(gen_output_seven[0]))
    else $error("pin b default wrong");
  AST_PIN_B1: assert property (@(posedge mclk) disable iff (sys_rst)
    output_pin_select_q[1]
    |=> shared_pin_b[0] == $past(gen_output_three[0]))
    else $error("pin b alternate wrong");

  AST_FIX_X: assert property (@(posedge mclk) disable iff (sys_rst)
    pulse_gen_mode_word_q == 16'h4444
    |=> axis_drive == {4{$past(ext_pulse_pair[0])}})
    else $error("fixed routing wrong");
  AST_SWX: assert property (@(posedge mclk) disable iff (sys_rst)
    s_swx_y |=> axis_drive[1] == $past(ext_pulse_pair[0]))
    else $error("picked x routing wrong");
  AST_SWY: assert property (@(posedge mclk) disable iff (sys_rst)
    s_swy_u |=> axis_drive[3] == $past(ext_pulse_pair[1]))
    else $error("picked y routing wrong");
  AST_HW: assert property (@(posedge mclk) disable iff (sys_rst)
    pulse_gen_mode_word_q == 16'h9000 |=> axis_handwheel == 4'h8)
    else $error("input type wrong");
endmodule

// ==== verification/asr_ext_src.sv ====
// External jog source and axis selector pins facing the router.
`timescale 1ns/1ns
module asr_ext_src
  import asr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] pattern,
  input wire logic [1:0] pick_code,
  output asr_pulse_t [3:0] ext_pulse_pair = '0,
  output logic axis_pick_hi = 1'b0,
  output logic axis_pick_lo = 1'b0
);
  // Pins change only after an edge, like a synchronised panel input.
  always @(posedge mclk) begin
    ext_pulse_pair <= pattern;
    axis_pick_hi <= pick_code[1];
    axis_pick_lo <= pick_code[0];
  end
endmodule

// ==== verification/axis_signal_router_irq_glue_tb.sv ====
// Self-checking testbench for the axis signal router.
`timescale 1ns/1ns
module axis_signal_router_irq_glue_tb;
  import asr_pkg::*;
  typedef struct packed {
    logic [15:0] pulse_gen_mode_word;
    logic [7:0] ext;
    logic [1:0] pick;
    logic [7:0] drv;
    logic [3:0] hw;
  } asr_row_t;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic irq_ev = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, got;
  logic wait_req, pick_hi, pick_lo;
  logic [7:0] ext_code = 8'h00;
  logic [1:0] pick_code = 2'h0;
  logic [3:0] g6 = 4'h3, g2 = 4'hC, g7 = 4'h5, g3 = 4'hA;
  logic [3:0] hw, pa, pb, ea, eb;
  logic [15:0] irq;
  logic [7:0] s;
  asr_pulse_t [3:0] ext, drv;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] sels [4] = '{8'h55, 8'hAA, 8'h39, 8'hC6};
  asr_row_t rows [12] = '{
    '{16'h0000, 8'hFF, 2'h0, 8'h00, 4'h0}, '{16'h1111, 8'h1B, 2'h0, 8'h1B, 4'h0},
    '{16'h4444, 8'h1B, 2'h0, 8'hFF, 4'h0}, '{16'h5555, 8'h1B, 2'h0, 8'hAA, 4'h0},
    '{16'h6666, 8'h1B, 2'h0, 8'h55, 4'h0}, '{16'h7777, 8'hE4, 2'h0, 8'hFF, 4'h0},
    '{16'h0002, 8'h1B, 2'h0, 8'h03, 4'h0}, '{16'h0002, 8'h1B, 2'h1, 8'h0C, 4'h0},
    '{16'h0002, 8'h1B, 2'h2, 8'h30, 4'h0}, '{16'h0003, 8'h1B, 2'h3, 8'h80, 4'h0},
    '{16'h8888, 8'hFF, 2'h0, 8'h00, 4'h0}, '{16'h9000, 8'hE4, 2'h0, 8'hC0, 4'h8}};

  always #4 mclk = ~mclk;

  asr_ext_src SRC (.mclk(mclk), .pattern(ext_code), .pick_code(pick_code),
    .ext_pulse_pair(ext), .axis_pick_hi(pick_hi), .axis_pick_lo(pick_lo));
  asr_router #(.AXES(4)) DUT (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wait_req), .ext_pulse_pair(ext),
    .axis_pick_hi(pick_hi), .axis_pick_lo(pick_lo), .irq_event(irq_ev),
    .gen_output_six(g6), .gen_output_two(g2), .gen_output_seven(g7),
    .gen_output_three(g3), .axis_drive(drv), .axis_handwheel(hw),
    .shared_pin_a(pa), .shared_pin_b(pb), .host_irq(irq));

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge, giving up with a failure after 50 more edges.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    @(posedge mclk);
    while (wait_req !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) fail_count++;
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(0, ASR_OFF_IRQSEL, 0); chk(got, 32'h0);
    bus(0, ASR_OFF_OUTSEL, 0); chk(got, 32'h0);
    chk({24'h0, pb, pa}, {24'h0, g7, g6});
    bus(1, 5'h04, 32'hFFFF); bus(0, 5'h04, 0); chk(got, 32'h0);
    foreach (rows[i]) begin
      ext_code <= rows[i].ext;
      pick_code <= rows[i].pick;
      bus(1, ASR_OFF_PGM, {16'h0, rows[i].pulse_gen_mode_word});
      bus(0, ASR_OFF_PGM, 0); chk(got, {16'h0, rows[i].pulse_gen_mode_word});
      chk({24'h0, drv}, {24'h0, rows[i].drv});
      chk({28'h0, hw}, {28'h0, rows[i].hw});
    end
    $display("test routing done");
    foreach (sels[k]) begin
      s = sels[k];
      for (int j = 0; j < 4; j++) begin
        ea[j] = s[2*j] ? g2[j] : g6[j];
        eb[j] = s[2*j+1] ? g3[j] : g7[j];
      end
      bus(1, ASR_OFF_OUTSEL, {24'h0, s});
      bus(0, ASR_OFF_OUTSEL, 0); chk(got & 32'hFF, {24'h0, s});
      chk({24'h0, eb, ea}, {24'h0, pb, pa});
    end
    $display("test output select done");
    for (int n = 0; n < 16; n++) begin
      bus(1, ASR_OFF_IRQSEL, 32'h5A5A5A50 | n);
      bus(0, ASR_OFF_IRQSEL, 0); chk(got & 32'hF, n);
      irq_ev <= 1'b1;
      @(posedge mclk);
      irq_ev <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({16'h0, irq}, (n inside {4, 5, 7, 10, 11, 12, 15}) ? 1 << n : 0);
      bus(0, ASR_OFF_INTERRUPT_STATUS, 0); chk(got & 32'h1, 32'h1);
      bus(1, ASR_OFF_INTERRUPT_STATUS, n * 32'h1111);
      bus(0, ASR_OFF_INTERRUPT_STATUS, 0); chk(got & 32'h1, 32'h0);
      chk({16'h0, irq}, 32'h0);
    end
    $display("test interrupt done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(0, ASR_OFF_IRQSEL, 0); chk(got, 32'h0);
    bus(0, ASR_OFF_PGM, 0); chk(got, 32'h0);
    chk({24'h0, drv}, 32'h0);
    $display("test second reset done");
    conclude();
  end
endmodule
